// ---- inc/dap_pkg.sv ----
// constants, types and register map of the digital audio port block
// assumes a 100 MHz system clock and decoders/encoders on the same clock
package dap_pkg;

  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned CONV_LATENCY_US  = 2500;
  localparam int unsigned CONV_LATENCY_CYC = CONV_LATENCY_US * (CLK_HZ / 1_000_000);

  localparam logic [7:0]  REG_CTRL_OFS     = 8'h00;
  localparam logic [7:0]  REG_STAT_OFS     = 8'h04;
  localparam logic [7:0]  REG_PER_OFS      = 8'h08;

  localparam int unsigned CTRL_OPT_SPDIF   = 0;
  localparam int unsigned CTRL_SPEED_LSB   = 1;
  localparam int unsigned CTRL_SEL_LSB     = 3;
  localparam int unsigned CTRL_CONV_EN     = 5;
  localparam logic [5:0]  CTRL_RST         = 6'h00;

  localparam logic [15:0] RATIO_MAX        = 16'h0007;
  localparam logic [7:0]  CS_BLOCK_LAST    = 8'hBF;
  localparam logic [3:0]  OPT_CHAN_BASE    = 4'h6;
  localparam int unsigned AVG_SHIFT        = 4;
  localparam logic [15:0] PER_RST          = 16'h0000;
  localparam logic [3:0]  CS_FS_SINGLE     = 4'h0;
  localparam logic [3:0]  CS_FS_DOUBLE     = 4'h1;
  localparam logic [3:0]  CS_FS_QUAD       = 4'h2;

  typedef enum logic [1:0] {
    SPEED_SINGLE = 2'b00,
    SPEED_DOUBLE = 2'b01,
    SPEED_QUAD   = 2'b10
  } speed_e;

  typedef enum logic [1:0] {
    PORT_AES  = 2'b00,
    PORT_COAX = 2'b01,
    PORT_OPT  = 2'b10,
    PORT_NONE = 2'b11
  } port_e;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_FILL = 2'b01,
    CONV_RUN  = 2'b10
  } conv_state_e;

  typedef struct packed {
    logic        valid;
    logic [2:0]  slot;
    logic [23:0] sample;
    logic        cs_bit;
    logic        pro;
    logic        pre_emph;
    logic        split;
  } rx_word_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    logic [23:0] sample;
  } host_word_s;

  typedef struct packed {
    logic        valid;
    port_e       port;
    logic [2:0]  slot;
    logic [23:0] sample;
  } tx_req_s;

  typedef struct packed {
    logic        valid;
    logic [2:0]  slot;
    logic [23:0] sample;
    logic        cs_bit;
  } tx_word_s;

  typedef struct packed {
    logic        valid;
    logic [23:0] left;
    logic [23:0] right;
  } conv_pair_s;

endpackage

// ---- core/dap_formats.sv ----
// digital audio port format handling: receive mapping, channel status regeneration,
// per-speed channel counts and the stereo rate converter front end
// assumes decoders/encoders on sys_clk; frame clocks of the three links arrive raw from pins
//
// What this block does
// R1 - channel status bits received on the balanced input are dropped unused
// R2 - every transmitted stereo stream carries a locally generated channel status header
// R3 - coaxial receiver accepts consumer and professional streams alike
// R4 - optical input detects two-channel stream, maps it to overall channels 7 and 8
// R5 - optical two-channel output takes its audio from optical output slots 1 and 2
// R6 - optical two-channel output always marks its header as consumer
// R7 - optical receiver passes 8, 4 or 2 channels at single, double, quad speed
// R8 - optical transmitter sends 8, 4 or 2 channels at single, double, quad speed
// R9 - double rate follows the sender identifier; quad rate only from software setting
// R10 - sources must be arranged so that at least two inputs are synchronous
// R11 - converter attaches to exactly one of three stereo inputs, output on reference
// R12 - converter runs only while input and reference rates differ by at most a factor of seven
// R13 - converter output starts a fixed latency after its input locks
// R14 - converter refuses split multi-link high-rate streams
// R15 - converter refused on optical input while it carries the multichannel format
// R16 - converter output emits a word every reference tick, silence when input fails
// R17 - selected converter input gets its own smoothed frame period recovery
// R18 - received pre-emphasis flag never reaches the host side
// R19 - one setting selects optical output format, multichannel after reset

////////////////////////////////////////////////////////////////////////////////
module dap_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_r[AW-1:0]];

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop)
      begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module dap_formats #(
  parameter int unsigned LAT_CYC    = dap_pkg::CONV_LATENCY_CYC,
  parameter int unsigned FIFO_DEPTH = 32
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire dap_pkg::rx_word_s   rx_aes,
  input  wire dap_pkg::rx_word_s   rx_coax,
  input  wire dap_pkg::rx_word_s   rx_opt,
  input  wire logic                opt_fmt_spdif,
  input  wire logic                opt_double_id,
  input  wire logic [2:0]          link_lrck,
  input  wire logic                ref_tick,
  output dap_pkg::host_word_s      host_aes,
  output dap_pkg::host_word_s      host_coax,
  output dap_pkg::host_word_s      host_opt,
  output dap_pkg::conv_pair_s      conv_out,
  input  wire dap_pkg::tx_req_s    tx_req,
  output dap_pkg::tx_word_s        tx_aes,
  output dap_pkg::tx_word_s        tx_coax,
  output dap_pkg::tx_word_s        tx_opt
);
  import dap_pkg::*;

  function automatic logic [3:0] chan_count(input speed_e sp);
    case (sp)
      SPEED_SINGLE: chan_count = 4'h8;
      SPEED_DOUBLE: chan_count = 4'h4;
      default:      chan_count = 4'h2;
    endcase
  endfunction

  // fresh header: professional flag in bit 0, rate code in bits 24..27, rest zero
  function automatic logic cs_gen(input logic [7:0] idx, input logic pro, input speed_e sp);
    logic [3:0] fs;
    fs = (sp == SPEED_SINGLE) ? CS_FS_SINGLE : (sp == SPEED_DOUBLE) ? CS_FS_DOUBLE : CS_FS_QUAD;
    if (idx == 8'h00)
    begin
      cs_gen = pro;
    end
    else if (idx >= 8'h18 && idx <= 8'h1B)
    begin
      cs_gen = fs[idx[1:0]];
    end
    else
    begin
      cs_gen = 1'b0;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register bus
  logic [5:0]  ctrl_r;
  logic        wb_req;
  logic [15:0] in_per_r;
  logic [15:0] ref_per_r;
  conv_state_e conv_st_r;
  logic        range_ok;
  logic        split_seen_r;
  logic        ovf_r;
  speed_e      speed_eff;
  speed_e      speed_reg;
  port_e       conv_sel;
  logic        opt_out_spdif;

  assign wb_req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign opt_out_spdif = ctrl_r[CTRL_OPT_SPDIF];
  assign conv_sel      = port_e'(ctrl_r[CTRL_SEL_LSB +: 2]);
  // the unused code 11 reads as single speed
  assign speed_reg     = (ctrl_r[CTRL_SPEED_LSB +: 2] == 2'b11) ? SPEED_SINGLE
                       : speed_e'(ctrl_r[CTRL_SPEED_LSB +: 2]);

  // quad has no identifier and must come from software
  assign speed_eff = (speed_reg == SPEED_QUAD) ? SPEED_QUAD      // R9
                   : opt_double_id ? SPEED_DOUBLE : speed_reg;  // R9

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= CTRL_RST;  // R19
    end
    else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL_OFS)
    begin
      ctrl_r <= wb_dat_i[5:0];  // R19
    end
  end

  // unmapped addresses answer zero, same timing
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        REG_CTRL_OFS: wb_dat_o <= {26'h000_0000, ctrl_r};
        REG_STAT_OFS: wb_dat_o <= {23'h00_0000, ovf_r, split_seen_r, range_ok, conv_st_r,
                                   speed_eff, opt_double_id, opt_fmt_spdif};
        REG_PER_OFS:  wb_dat_o <= {ref_per_r, in_per_r};
        default:      wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive mapping; channel status and emphasis are deliberately not forwarded
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_aes  <= '0;
      host_coax <= '0;
      host_opt  <= '0;
    end
    else
    begin
      host_aes.valid  <= rx_aes.valid;  // R1 R18
      host_aes.chan   <= {3'h0, rx_aes.slot[0]};
      host_aes.sample <= rx_aes.sample;
      // no check of the professional flag here
      host_coax.valid  <= rx_coax.valid;  // R3 R18
      host_coax.chan   <= {3'h0, rx_coax.slot[0]};
      host_coax.sample <= rx_coax.sample;
      if (opt_fmt_spdif)
      begin
        host_opt.valid <= rx_opt.valid && rx_opt.slot < 3'h2;  // R4
      end
      else
      begin
        host_opt.valid <= rx_opt.valid && {1'b0, rx_opt.slot} < chan_count(speed_eff);  // R7
      end
      host_opt.chan   <= OPT_CHAN_BASE + {1'b0, rx_opt.slot};  // R4
      host_opt.sample <= rx_opt.sample;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit with regenerated channel status
  logic [7:0] cs_idx_r [3];
  logic       tx_lead;

  assign tx_lead = tx_req.valid && tx_req.slot == 3'h0;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_idx_r <= '{default: 8'h00};
    end
    else if (tx_lead && tx_req.port != PORT_NONE)
    begin
      cs_idx_r[tx_req.port] <= (cs_idx_r[tx_req.port] == CS_BLOCK_LAST) ? 8'h00
                                : cs_idx_r[tx_req.port] + 8'h01;  // R2
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_aes  <= '0;
      tx_coax <= '0;
      tx_opt  <= '0;
    end
    else
    begin
      tx_aes.valid  <= tx_req.valid && tx_req.port == PORT_AES && tx_req.slot < 3'h2;
      tx_aes.slot   <= tx_req.slot;
      tx_aes.sample <= tx_req.sample;
      tx_aes.cs_bit <= cs_gen(cs_idx_r[PORT_AES], 1'b1, speed_eff);  // R2
      tx_coax.valid  <= tx_req.valid && tx_req.port == PORT_COAX && tx_req.slot < 3'h2;
      tx_coax.slot   <= tx_req.slot;
      tx_coax.sample <= tx_req.sample;
      tx_coax.cs_bit <= cs_gen(cs_idx_r[PORT_COAX], 1'b0, speed_eff);  // R2
      if (opt_out_spdif)
      begin
        tx_opt.valid <= tx_req.valid && tx_req.port == PORT_OPT && tx_req.slot < 3'h2;  // R5
      end
      else
      begin
        tx_opt.valid <= tx_req.valid && tx_req.port == PORT_OPT
                        && {1'b0, tx_req.slot} < chan_count(speed_eff);  // R8
      end
      tx_opt.slot   <= tx_req.slot;
      tx_opt.sample <= tx_req.sample;
      // consumer only; the multichannel format ignores this bit
      tx_opt.cs_bit <= opt_out_spdif && cs_gen(cs_idx_r[PORT_OPT], 1'b0, speed_eff);  // R6
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame clock sampling and period recovery of the converter input
  logic [2:0]  lrck_s1_r;
  logic [2:0]  lrck_s2_r;
  logic [2:0]  lrck_s3_r;
  logic [2:0]  lrck_lvl_r;
  logic [2:0]  lrck_old_r;
  logic [15:0] in_cnt_r;
  logic [15:0] ref_cnt_r;
  logic        sel_rise;
  logic [1:0]  sel_q_r;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lrck_s1_r  <= 3'h0;
      lrck_s2_r  <= 3'h0;
      lrck_s3_r  <= 3'h0;
      lrck_lvl_r <= 3'h0;
      lrck_old_r <= 3'h0;
    end
    else
    begin
      lrck_s1_r  <= link_lrck;
      lrck_s2_r  <= lrck_s1_r;
      lrck_s3_r  <= lrck_s2_r;
      lrck_lvl_r <= (lrck_s2_r & lrck_s3_r) | (lrck_lvl_r & (lrck_s2_r ^ lrck_s3_r));
      lrck_old_r <= lrck_lvl_r;
    end
  end

  assign sel_rise = (conv_sel != PORT_NONE) && lrck_lvl_r[conv_sel] && !lrck_old_r[conv_sel];

  // a slow average keeps frame jitter away from the rate ratio; the first full period is loaded whole, so lock comes after two frame edges
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_cnt_r <= 16'h0000;
      in_per_r <= PER_RST;
      sel_q_r  <= 2'h3;
    end
    else
    begin
      sel_q_r <= conv_sel;
      // a full count means no frame edge since selection or loss, so it is no period
      if (sel_q_r != conv_sel)
      begin
        in_cnt_r <= 16'hFFFF;
        in_per_r <= PER_RST;
      end
      else if (sel_rise)
      begin
        in_cnt_r <= 16'h0000;
        if (in_cnt_r != 16'hFFFF)
        begin
          in_per_r <= (in_per_r == PER_RST) ? in_cnt_r
                      : in_per_r + 16'((in_cnt_r >> AVG_SHIFT) - (in_per_r >> AVG_SHIFT));  // R17
        end
      end
      else if (in_cnt_r != 16'hFFFF)
      begin
        in_cnt_r <= in_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_cnt_r <= 16'h0000;
      ref_per_r <= PER_RST;
    end
    else if (ref_tick)
    begin
      ref_cnt_r <= 16'h0000;
      ref_per_r <= ref_cnt_r;
    end
    else if (ref_cnt_r != 16'hFFFF)
    begin
      ref_cnt_r <= ref_cnt_r + 16'h0001;
    end
  end

  assign range_ok = in_per_r != PER_RST && ref_per_r != PER_RST && in_cnt_r != 16'hFFFF
                    && 20'(in_per_r) * 20'(RATIO_MAX) >= 20'(ref_per_r)
                    && 20'(ref_per_r) * 20'(RATIO_MAX) >= 20'(in_per_r);  // R12

  //////////////////////////////////////////////////////////////////////////////
  // rate converter front end
  rx_word_s    conv_in;
  logic        conv_allow;
  logic [31:0] lat_cnt_r;
  logic [23:0] left_r;
  logic        pair_vld_r;
  logic [47:0] pair_r;
  logic        fifo_rdy;
  logic        fifo_vld;
  logic [47:0] fifo_dat;
  logic        drain;

  always_comb
  begin
    case (conv_sel)  // R11
      PORT_AES:  conv_in = rx_aes;
      PORT_COAX: conv_in = rx_coax;
      PORT_OPT:  conv_in = rx_opt;
      default:   conv_in = '0;
    endcase
  end

  assign conv_allow = ctrl_r[CTRL_CONV_EN] && conv_sel != PORT_NONE                   // R11
                      && !(conv_sel == PORT_OPT && !opt_fmt_spdif)                    // R15
                      && !split_seen_r && range_ok;                                   // R12 R14

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      split_seen_r <= 1'b0;
    end
    else if (conv_in.valid && conv_in.split)
    begin
      split_seen_r <= 1'b1;  // R14
    end
    else if (sel_q_r != conv_sel)
    begin
      split_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_st_r <= CONV_IDLE;
      lat_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      case (conv_st_r)
        CONV_IDLE:
        begin
          lat_cnt_r <= 32'h0000_0000;
          if (conv_allow)
          begin
            conv_st_r <= CONV_FILL;
          end
        end
        CONV_FILL:
        begin
          lat_cnt_r <= lat_cnt_r + 32'h0000_0001;
          if (!conv_allow)
          begin
            conv_st_r <= CONV_IDLE;
          end
          else if (lat_cnt_r >= 32'(LAT_CYC - 1))
          begin
            conv_st_r <= CONV_RUN;  // R13
          end
        end
        CONV_RUN:
        begin
          if (!conv_allow)
          begin
            conv_st_r <= CONV_IDLE;
          end
        end
        default: conv_st_r <= CONV_IDLE;
      endcase
    end
  end

  // left word waits for its right partner; a pair stalls here while the buffer is full
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_r     <= 24'h00_0000;
      pair_vld_r <= 1'b0;
      pair_r     <= 48'h0000_0000_0000;
      ovf_r      <= 1'b0;
    end
    else
    begin
      if (pair_vld_r && fifo_rdy)
      begin
        pair_vld_r <= 1'b0;
      end
      if (conv_in.valid && conv_st_r != CONV_IDLE)
      begin
        if (conv_in.slot == 3'h0)
        begin
          left_r <= conv_in.sample;
        end
        else if (conv_in.slot == 3'h1)
        begin
          if (pair_vld_r && !fifo_rdy)
          begin
            ovf_r <= 1'b1;
          end
          else
          begin
            pair_vld_r <= 1'b1;
            pair_r     <= {left_r, conv_in.sample};
          end
        end
      end
    end
  end

  assign drain = ref_tick && conv_st_r == CONV_RUN;

  dap_fifo #(
    .WIDTH (48),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (pair_vld_r),
    .in_ready  (fifo_rdy),
    .in_data   (pair_r),
    .out_valid (fifo_vld),
    .out_ready (drain),
    .out_data  (fifo_dat)
  );

  // one word on every reference tick whatever the input does; silence fills the gaps
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_out <= '0;
    end
    else
    begin
      conv_out.valid <= ref_tick;  // R16
      if (drain && fifo_vld)
      begin
        conv_out.left  <= fifo_dat[47:24];
        conv_out.right <= fifo_dat[23:0];
      end
      else if (ref_tick)
      begin
        conv_out.left  <= 24'h00_0000;  // R16
        conv_out.right <= 24'h00_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sequence s_opt_lead;
    rx_opt.valid && opt_fmt_spdif && rx_opt.slot == 3'h0;
  endsequence

  property p_opt_spdif_map;
    @(posedge sys_clk) disable iff (!rst_n)
    s_opt_lead |=> host_opt.valid && host_opt.chan == 4'h6;
  endproperty
  a_opt_spdif_map: assert property (p_opt_spdif_map) else $error("optical spdif slot not mapped"); // R4

  property p_rx_count;
    @(posedge sys_clk) disable iff (!rst_n)
    rx_opt.valid && !opt_fmt_spdif && speed_eff == SPEED_DOUBLE && rx_opt.slot >= 3'h4 |=> !host_opt.valid;
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("extra optical channel received"); // R7

  property p_tx_count;
    @(posedge sys_clk) disable iff (!rst_n)
    tx_req.valid && tx_req.port == PORT_OPT && speed_eff == SPEED_QUAD && tx_req.slot >= 3'h2
    |=> !tx_opt.valid;
  endproperty
  a_tx_count: assert property (p_tx_count) else $error("extra optical channel sent"); // R8

  property p_opt_consumer;
    @(posedge sys_clk) disable iff (!rst_n)
    tx_lead && tx_req.port == PORT_OPT && cs_idx_r[PORT_OPT] == 8'h00
    |=> tx_opt.valid && !tx_opt.cs_bit;
  endproperty
  a_opt_consumer: assert property (p_opt_consumer) else $error("optical header not consumer"); // R6

  property p_speed;
    @(posedge sys_clk) disable iff (!rst_n)
    (speed_reg == SPEED_QUAD |-> speed_eff == SPEED_QUAD)
    and (opt_double_id && speed_reg == SPEED_SINGLE |-> speed_eff == SPEED_DOUBLE);
  endproperty
  a_speed: assert property (p_speed) else $error("speed selection wrong"); // R9

  property p_opt_refuse;
    @(posedge sys_clk) disable iff (!rst_n)
    conv_sel == PORT_OPT && !opt_fmt_spdif ##1 conv_sel == PORT_OPT && !opt_fmt_spdif
    |=> conv_st_r == CONV_IDLE;
  endproperty
  a_opt_refuse: assert property (p_opt_refuse) else $error("converter on multichannel input"); // R15

  sequence s_run_tick;
    ref_tick && conv_st_r == CONV_RUN;
  endsequence

  property p_continuous;
    @(posedge sys_clk) disable iff (!rst_n)
    ref_tick |=> conv_out.valid ##1 !conv_out.valid || $past(ref_tick);
  endproperty
  a_continuous: assert property (p_continuous) else $error("converter output not continuous"); // R16

  property p_latency;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(conv_st_r == CONV_RUN) |-> $past(lat_cnt_r) >= 32'(LAT_CYC - 1);
  endproperty
  a_latency: assert property (p_latency) else $error("converter started early"); // R13

  property p_range;
    @(posedge sys_clk) disable iff (!rst_n)
    s_run_tick |-> $past(range_ok && !split_seen_r);
  endproperty
  a_range: assert property (p_range) else $error("converter running out of range"); // R12 R14

  property p_wb_ack;
    @(posedge sys_clk) disable iff (!rst_n)
    wb_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus answer timing wrong");
endmodule

// ---- tb/audio_src.sv ----
// partner: stereo source on the coaxial link
// assumes sys_clk from the bench; frame clock runs only while en
module audio_src (
  input  wire logic        sys_clk,
  input  wire logic        en,
  output logic             lrck,
  output dap_pkg::rx_word_s w
);
  timeunit 1ns;
  timeprecision 1ps;
  import dap_pkg::*;
  logic [2:0]  s;
  logic [23:0] n;
  ////////////////////////////////////////
  initial
  begin
    lrck = 1'b0;
    w = '0;
    s = 3'h0;
    n = 24'h000000;
  end
  // same frame rate as the reference, so this source counts as synchronous
  always #80 lrck = en ? ~lrck : 1'b0;
  always @(posedge sys_clk)
  begin
    s <= {s[1:0], lrck};
    w.valid <= 1'b0;
    w.sample <= ~w.sample;
    if (s[1] & ~s[2])
    begin
      n <= n + 24'h000001;
      w <= {1'b1, 3'h0, n, 4'b1110};
    end
    else if (w.valid && w.slot == 3'h0)
      w <= {1'b1, 3'h1, ~w.sample, 4'b0110};
  end
endmodule

// ---- tb/tb_top.sv ----
// bench: optical traffic at every speed and mode, converter bring-up
// assumes LAT_CYC cut to 20 and a reference tick at the link frame rate
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dap_pkg::*;
  logic        sys_clk, rst_n, cyc, stb, we, opt_sp, dbl, ref_tick, en, lrck, ack, pr;
  logic [7:0]  adr;
  logic [31:0] dat, rd, dout, seed;
  logic [3:0]  t;
  rx_word_s    rx_opt, rx_coax, pv;
  host_word_s  h_aes, h_coax, h_opt;
  conv_pair_s  conv;
  tx_req_s     tx;
  tx_word_s    t_aes, t_coax, t_opt;
  int          err_count, n_tests, k, s;
  ////////////////////////////////////////
  dap_formats #(.LAT_CYC(20), .FIFO_DEPTH(32)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
    .rx_aes(rx_coax), .rx_coax(rx_coax), .rx_opt(rx_opt), .opt_fmt_spdif(opt_sp),
    .opt_double_id(dbl), .link_lrck({1'b0, lrck, 1'b0}), .ref_tick(ref_tick),
    .host_aes(h_aes), .host_coax(h_coax), .host_opt(h_opt), .conv_out(conv),
    .tx_req(tx), .tx_aes(t_aes), .tx_coax(t_coax), .tx_opt(t_opt));
  audio_src src (.sys_clk(sys_clk), .en(en), .lrck(lrck), .w(rx_coax));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask
  task stop_test;
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge sys_clk); while (ack !== 1'b1 && ++n < 50);
    chk("wb_ack", 1, ack);
    rd = dout;
    {cyc, stb} <= 2'b00;
  endtask
  // one receive word and one transmit request on the optical port together
  task automatic opt(input logic [2:0] sl, input logic [1:0] sp);
    logic [23:0] v;
    logic        keep;
    v = 24'($random(seed));
    keep = sl < (opt_sp ? 4'd2 : 4'd8 >> sp);
    @(posedge sys_clk);
    rx_opt <= {1'b1, sl, v, 4'b1110};
    tx <= {1'b1, PORT_OPT, sl, ~v};
    @(posedge sys_clk);
    rx_opt.valid <= 1'b0;
    tx.valid <= 1'b0;
    #1;
    chk("opt_rx", keep, h_opt.valid);
    chk("opt_tx", keep, t_opt.valid);
    if (keep) chk("opt_rx_w", {4'h6 + sl, v}, {h_opt.chan, h_opt.sample});
    if (keep) chk("opt_tx_w", {sl, ~v}, {t_opt.slot, t_opt.sample});
    if (keep && sp == 2'b00) chk("opt_cs", 0, t_opt.cs_bit);
    chk("tx_other", 0, {t_aes.valid, t_coax.valid});
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // coaxial words and converter ticks are watched all run long
  always @(posedge sys_clk)
  begin
    if (pv.valid) chk("coax", {4'h8, pv.slot[0], pv.sample}, {h_coax.valid, h_coax.chan, h_coax.sample});
    if (pv.valid) chk("aes", {4'h8, pv.slot[0], pv.sample}, {h_aes.valid, h_aes.chan, h_aes.sample});
    if (pr && conv.left != 24'h00_0000) chk("conv_pair", 24'(~conv.left), conv.right);
    pv <= rx_coax;
    if (pr) chk("conv_tick", 1, conv.valid);
    pr <= ref_tick & rst_n;
    t <= t + 4'h1;
    ref_tick <= t == 4'hF;
  end
  initial
  begin
    #300_000;
    err_count++;
    stop_test;
  end
  initial
  begin
    seed = 32'hC2C1;
    {cyc, stb, we, adr, dat, opt_sp, dbl, en, pr, t, ref_tick} = '0;
    {rx_opt, pv, tx} = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    wb(0, REG_CTRL_OFS, 0);
    chk("ctrl_rst", 0, rd);
    wb(0, 8'h1C, 0);
    chk("unmapped", 0, rd);
    for (k = 0; k < 6; k++)
    begin
      opt_sp <= k[0];
      wb(1, REG_CTRL_OFS, k);
      wb(0, REG_STAT_OFS, 0);
      chk("stat", k, {rd[3:2], rd[0]});
      for (s = 0; s < 8; s++) opt(3'(s), 2'(k >> 1));
    end
    opt_sp <= 1'b0;
    dbl <= 1'b1;
    wb(1, REG_CTRL_OFS, 0);
    wb(0, REG_STAT_OFS, 0);
    chk("dbl", 3'b011, {rd[3:2], rd[1]});
    dbl <= 1'b0;
    en <= 1'b1;
    wb(1, REG_CTRL_OFS, 32'h28);
    for (k = 0; k < 300 && rd[5:4] !== 2'b10; k++) wb(0, REG_STAT_OFS, 0);
    chk("conv_run", 2, rd[5:4]);
    wb(1, REG_CTRL_OFS, 32'h30);
    repeat (40) @(posedge sys_clk);
    wb(0, REG_STAT_OFS, 0);
    chk("conv_opt", 0, rd[5:4]);
    en <= 1'b0;
    repeat (40) @(posedge sys_clk);
    stop_test;
  end
endmodule
